// ===== hw/lmcfg_top.v
// Notes on behaviour
// - bits 4-0 hold chained device count minus one, reset code seven
// - bit 8 enables pre-discharge, reset enabled
// - bit 12 enables power saving, reset disabled
// - bits 14-13 power-saving-plus: off, high, middle, low level; reset off
// - bit 15 enables open-load removal, reset disabled
// - bits 20-16 hold scan line count minus one, reset sixteen lines
// - bits 23-21 give sub-periods as sixteen times code plus one
// - bit 27 picks low or high multiplier range, reset low
// - bits 31-28 give grayscale clock ratio code plus one, reset eight
// - bits 37-35 delay red group 0 to 7 clocks, forward mode only
// - bits 40-38 delay green group 0 to 7 clocks, forward mode only
// - bits 43-41 delay blue group 0 to 7 clocks, forward mode only
// - bits 47-46 give stack size; single mode needs sixteen lines or fewer
// - timing bits 9-0 give segment clocks 128 to 1024, others give 128
// - timing bits 40-37 give line switch: zero is 45, else multiples of 30
// - timing bits 46-41 give black field adjust 0 to 63 clocks
`timescale 1ns/1ps
`include "lmcfg_defines.vh"

module lmcfg_top
(
    input wire ref_clk,
    input wire nrst,
    input wire cmd_valid,
    input wire [15:0] cmd_id,
    input wire [47:0] cmd_data,
    output reg rd_valid_reg,
    output reg [47:0] rd_data_reg,
    output reg [47:0] common_config_primary_reg,
    output reg [47:0] common_config_timing_reg,
    output reg [5:0] device_count_reg,
    output reg predischarge_enable_reg,
    output reg power_saving_enable_reg,
    output reg [1:0] power_saving_plus_level_reg,
    output reg [2:0] power_saving_plus_sel_reg,
    output reg open_load_removal_enable_reg,
    output reg [5:0] scan_line_count_reg,
    output reg [7:0] subperiod_count_reg,
    output reg multiplier_range_select_reg,
    output reg [4:0] multiplier_ratio_reg,
    output reg [8:0] group_delay_reg,
    output reg [1:0] module_stack_size_reg,
    output reg stack_config_error_reg,
    output reg [10:0] segment_clock_count_reg,
    output reg [8:0] line_switch_interval_reg,
    output reg [5:0] black_field_adjust_reg
);

    // five-bit count codes mean code plus one
    function [5:0] lmcfg_count_of;
        input [4:0] code;
        begin
            lmcfg_count_of = {1'h0, code} + 6'h01;
        end
    endfunction

    // a command counts only while the port flags it present
    function lmcfg_cmd_hit;
        input valid;
        input [15:0] id;
        input [15:0] expected;
        begin
            lmcfg_cmd_hit = valid && (id == expected);
        end
    endfunction

    reg [47:0] primary_next;
    reg [47:0] timing_next;
    reg [1:0] stack_next;
    reg [2:0] psp_sel_next;
    wire [10:0] seg_dec;
    wire [8:0] swt_dec;
    wire [5:0] blk_dec;
    wire [1:0] mod_code;
    wire [1:0] psp_code;
    wire [5:0] scan_count;
    wire wr_primary;
    wire wr_timing;
    wire rd_primary;
    wire rd_timing;
    wire [8:0] group_delay_next;

    assign mod_code = common_config_primary_reg[`LMCFG_MOD_HI:`LMCFG_MOD_LO];
    assign psp_code = common_config_primary_reg[`LMCFG_PSP_HI:`LMCFG_PSP_LO];
    assign scan_count = lmcfg_count_of(
        common_config_primary_reg[`LMCFG_SCAN_HI:`LMCFG_SCAN_LO]);

    // command decode shared by the write merge and the read-back
    assign wr_primary = lmcfg_cmd_hit(cmd_valid, cmd_id, `LMCFG_CMD_WR_PRIMARY);
    assign wr_timing = lmcfg_cmd_hit(cmd_valid, cmd_id, `LMCFG_CMD_WR_TIMING);
    assign rd_primary = lmcfg_cmd_hit(cmd_valid, cmd_id, `LMCFG_CMD_RD_PRIMARY);
    assign rd_timing = lmcfg_cmd_hit(cmd_valid, cmd_id, `LMCFG_CMD_RD_TIMING);

    lmcfg_timing_decode u_timing_decode
    (
        .timing_cfg(common_config_timing_reg),
        .segment_clocks(seg_dec),
        .switch_clocks(swt_dec),
        .black_clocks(blk_dec)
    );

    // merge a full-word write; reserved bits keep their fixed reset values
    // so a careless host cannot disturb them and reads stay predictable
    always @*
    begin
        primary_next = common_config_primary_reg;
        timing_next = common_config_timing_reg;
        if (wr_primary)
            primary_next = (cmd_data & `LMCFG_PRIMARY_WMASK)
                | (`LMCFG_PRIMARY_RESET & ~`LMCFG_PRIMARY_WMASK);
        if (wr_timing)
            timing_next = (cmd_data & `LMCFG_TIMING_WMASK)
                | (`LMCFG_TIMING_RESET & ~`LMCFG_TIMING_WMASK);
    end

    // stacking size and power-saving-plus level decode
    always @*
    begin
        case (mod_code)
            `LMCFG_MOD_SINGLE: stack_next = `LMCFG_STACK_ONE;
            `LMCFG_MOD_TRIPLE: stack_next = `LMCFG_STACK_THREE;
            default: stack_next = `LMCFG_STACK_TWO;
        endcase
        // one-hot: bit 2 high saving, bit 1 middle, bit 0 low
        case (psp_code)
            `LMCFG_PSP_OFF: psp_sel_next = `LMCFG_PSP_SEL_OFF;
            `LMCFG_PSP_HIGH: psp_sel_next = `LMCFG_PSP_SEL_HIGH;
            `LMCFG_PSP_MID: psp_sel_next = `LMCFG_PSP_SEL_MID;
            default: psp_sel_next = `LMCFG_PSP_SEL_LOW;
        endcase
    end

    // register storage and read-back over the serial command ids
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            common_config_primary_reg <= `LMCFG_PRIMARY_RESET;
            common_config_timing_reg <= `LMCFG_TIMING_RESET;
            rd_valid_reg <= 1'h0;
            rd_data_reg <= 48'h0000_0000_0000;
        end
        else
        begin
            common_config_primary_reg <= primary_next;
            common_config_timing_reg <= timing_next;
            // only the documented ids reach the registers; others are ignored
            rd_valid_reg <= rd_primary || rd_timing;
            // a read beside a write returns the old word, the merge lands later
            if (rd_primary)
                rd_data_reg <= common_config_primary_reg;
            else if (rd_timing)
                rd_data_reg <= common_config_timing_reg;
        end
    end

    // decoded settings, one cycle behind the stored registers
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            device_count_reg <= `LMCFG_DEV_COUNT_RESET;
            predischarge_enable_reg <= `LMCFG_PDC_RESET;
            power_saving_enable_reg <= 1'h0;
            power_saving_plus_level_reg <= `LMCFG_PSP_OFF;
            power_saving_plus_sel_reg <= `LMCFG_PSP_SEL_OFF;
            open_load_removal_enable_reg <= 1'h0;
            scan_line_count_reg <= `LMCFG_SCAN_COUNT_RESET;
            subperiod_count_reg <= `LMCFG_SUBP_STEP;
            multiplier_range_select_reg <= 1'h0;
            multiplier_ratio_reg <= `LMCFG_MUL_RATIO_RESET;
            module_stack_size_reg <= `LMCFG_STACK_TWO;
            stack_config_error_reg <= 1'h0;
            segment_clock_count_reg <= `LMCFG_SEG_DEFAULT;
            line_switch_interval_reg <= `LMCFG_SWT_RESET;
            black_field_adjust_reg <= 6'h00;
        end
        else
        begin
            device_count_reg <= lmcfg_count_of(
                common_config_primary_reg[`LMCFG_CHIP_HI:`LMCFG_CHIP_LO]);
            predischarge_enable_reg <= common_config_primary_reg[`LMCFG_PDC_BIT];
            power_saving_enable_reg <= common_config_primary_reg[`LMCFG_PS_BIT];
            power_saving_plus_level_reg <= psp_code;
            power_saving_plus_sel_reg <= psp_sel_next;
            open_load_removal_enable_reg <= common_config_primary_reg[`LMCFG_OLR_BIT];
            scan_line_count_reg <= scan_count;
            subperiod_count_reg <= ({5'h00,
                common_config_primary_reg[`LMCFG_SUBP_HI:`LMCFG_SUBP_LO]} + 8'h01)
                * `LMCFG_SUBP_STEP;
            multiplier_range_select_reg <= common_config_primary_reg[`LMCFG_RANGE_BIT];
            multiplier_ratio_reg <= {1'h0,
                common_config_primary_reg[`LMCFG_MUL_HI:`LMCFG_MUL_LO]} + 5'h01;
            module_stack_size_reg <= stack_next;
            // the host owns the line limit; we only flag a violation
            stack_config_error_reg <= (mod_code == `LMCFG_MOD_SINGLE)
                && (scan_count > `LMCFG_SCAN_SINGLE_MAX);
            segment_clock_count_reg <= seg_dec;
            line_switch_interval_reg <= swt_dec;
            black_field_adjust_reg <= blk_dec;
        end
    end

    // three colour group delays: red, green, blue, adjacent 3-bit fields
    // the pwm engine applies them only in forward mode, so no gating here
    genvar gi;
    generate
        for (gi = 0; gi < `LMCFG_GRP_COUNT; gi = gi + 1)
        begin : g_delay
            assign group_delay_next[gi*`LMCFG_DLY_W +: `LMCFG_DLY_W] =
                common_config_primary_reg[`LMCFG_DLY_R_LO + gi*`LMCFG_DLY_W
                +: `LMCFG_DLY_W];
        end
    endgenerate

    // one process for all three fields keeps the register single-driven
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            group_delay_reg <= `LMCFG_GRP_DLY_RESET;
        else
            group_delay_reg <= group_delay_next;
    end

endmodule

// ===== inc/lmcfg_defines.vh
`ifndef LMCFG_DEFINES_VH
`define LMCFG_DEFINES_VH

// serial command identifiers
`define LMCFG_CMD_WR_PRIMARY 16'haa00
`define LMCFG_CMD_WR_TIMING 16'haa01
`define LMCFG_CMD_RD_PRIMARY 16'haa60
`define LMCFG_CMD_RD_TIMING 16'haa61

// register width, reset values and writable-bit masks
`define LMCFG_REG_W 48
`define LMCFG_PRIMARY_RESET 48'h1000_700f_0107
`define LMCFG_PRIMARY_WMASK 48'hcff8_f8ff_f11f
`define LMCFG_TIMING_RESET 48'h00e0_0094_a400
`define LMCFG_TIMING_WMASK 48'h7fff_ffff_ffff

// primary register fields
`define LMCFG_CHIP_LO 0
`define LMCFG_CHIP_HI 4
`define LMCFG_PDC_BIT 8
`define LMCFG_PS_BIT 12
`define LMCFG_PSP_LO 13
`define LMCFG_PSP_HI 14
`define LMCFG_OLR_BIT 15
`define LMCFG_SCAN_LO 16
`define LMCFG_SCAN_HI 20
`define LMCFG_SUBP_LO 21
`define LMCFG_SUBP_HI 23
`define LMCFG_RANGE_BIT 27
`define LMCFG_MUL_LO 28
`define LMCFG_MUL_HI 31
`define LMCFG_DLY_R_LO 35
`define LMCFG_DLY_W 3
`define LMCFG_MOD_LO 46
`define LMCFG_MOD_HI 47

// timing register fields
`define LMCFG_SEG_LO 0
`define LMCFG_SEG_HI 9
`define LMCFG_SWT_LO 37
`define LMCFG_SWT_HI 40
`define LMCFG_BLK_LO 41
`define LMCFG_BLK_HI 46

// decode constants
`define LMCFG_SEG_MIN_CODE 10'h07f
`define LMCFG_SEG_DEFAULT 11'h080
`define LMCFG_SWT_FIRST 9'h02d
`define LMCFG_SWT_STEP 9'h01e
`define LMCFG_SUBP_STEP 8'h10
`define LMCFG_SCAN_SINGLE_MAX 6'h10
`define LMCFG_MOD_SINGLE 2'h1
`define LMCFG_MOD_TRIPLE 2'h3
`define LMCFG_STACK_ONE 2'h1
`define LMCFG_STACK_TWO 2'h2
`define LMCFG_STACK_THREE 2'h3
`define LMCFG_PSP_OFF 2'h0
`define LMCFG_PSP_HIGH 2'h1
`define LMCFG_PSP_MID 2'h2
`define LMCFG_PSP_SEL_OFF 3'h0
`define LMCFG_PSP_SEL_HIGH 3'h4
`define LMCFG_PSP_SEL_MID 3'h2
`define LMCFG_PSP_SEL_LOW 3'h1
`define LMCFG_GRP_COUNT 3

// decoded output reset values, the meaning of the register reset words
`define LMCFG_DEV_COUNT_RESET 6'h08
`define LMCFG_PDC_RESET 1'h1
`define LMCFG_SCAN_COUNT_RESET 6'h10
`define LMCFG_MUL_RATIO_RESET 5'h08
`define LMCFG_SWT_RESET 9'h0f0
`define LMCFG_GRP_DLY_RESET 9'h000

`endif

// ===== hw/lmcfg_timing_decode.v
`timescale 1ns/1ps
`include "lmcfg_defines.vh"

module lmcfg_timing_decode
(
    input wire [47:0] timing_cfg,
    output reg [10:0] segment_clocks,
    output reg [8:0] switch_clocks,
    output reg [5:0] black_clocks
);

    reg [9:0] seg_code;
    reg [3:0] swt_code;

    // segment length, interval between lines, black field adjust
    always @*
    begin
        seg_code = timing_cfg[`LMCFG_SEG_HI:`LMCFG_SEG_LO];
        swt_code = timing_cfg[`LMCFG_SWT_HI:`LMCFG_SWT_LO];
        // codes below the minimum are unlisted and fall back to the default
        if (seg_code >= `LMCFG_SEG_MIN_CODE)
            segment_clocks = {1'h0, seg_code} + 11'h001;
        else
            segment_clocks = `LMCFG_SEG_DEFAULT;
        // code zero is a special short interval, others step by thirty
        if (swt_code == 4'h0)
            switch_clocks = `LMCFG_SWT_FIRST;
        else
            switch_clocks = ({5'h00, swt_code} + 9'h001) * `LMCFG_SWT_STEP;
        black_clocks = timing_cfg[`LMCFG_BLK_HI:`LMCFG_BLK_LO];
    end

endmodule

// ===== verif/lmcfg_assertions.sv
`timescale 1ns/1ps
`include "lmcfg_defines.vh"
module lmcfg_assertions
(
    input wire ref_clk,
    input wire nrst,
    input wire cmd_valid,
    input wire [15:0] cmd_id,
    input wire [47:0] cmd_data,
    input wire rd_valid_reg,
    input wire [47:0] rd_data_reg,
    input wire [47:0] common_config_primary_reg,
    input wire [47:0] common_config_timing_reg,
    input wire [5:0] device_count_reg,
    input wire [7:0] subperiod_count_reg,
    input wire [4:0] multiplier_ratio_reg
);
    // short aliases keep the properties readable
    wire [47:0] p = common_config_primary_reg;
    wire [47:0] t = common_config_timing_reg;
    wire wr_p = cmd_valid && cmd_id == `LMCFG_CMD_WR_PRIMARY;
    wire wr_t = cmd_valid && cmd_id == `LMCFG_CMD_WR_TIMING;
    wire rd_p = cmd_valid && cmd_id == `LMCFG_CMD_RD_PRIMARY;
    wire rd_t = cmd_valid && cmd_id == `LMCFG_CMD_RD_TIMING;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_wr_p;
        wr_p |=> p == (($past(cmd_data) & `LMCFG_PRIMARY_WMASK)
            | (`LMCFG_PRIMARY_RESET & ~`LMCFG_PRIMARY_WMASK));
    endproperty
    a_wr_p: assert property (p_wr_p) else $error("primary write not merged");
    property p_wr_t;
        wr_t |=> t == (($past(cmd_data) & `LMCFG_TIMING_WMASK)
            | (`LMCFG_TIMING_RESET & ~`LMCFG_TIMING_WMASK));
    endproperty
    a_wr_t: assert property (p_wr_t) else $error("timing write not merged");
    property p_keep;
        !wr_p |=> $stable(p);
    endproperty
    a_keep: assert property (p_keep) else $error("primary changed unasked");
    property p_rd;
        rd_p |=> rd_valid_reg && rd_data_reg == $past(p);
    endproperty
    a_rd: assert property (p_rd) else $error("primary read wrong");
    property p_quiet;
        !(rd_p || rd_t) |=> !rd_valid_reg;
    endproperty
    a_quiet: assert property (p_quiet) else $error("read answer unasked");
    property p_dev;
        device_count_reg == $past(p[4:0]) + 6'h1;
    endproperty
    a_dev: assert property (p_dev) else $error("device count wrong");
    property p_subp;
        subperiod_count_reg == ($past(p[23:21]) + 8'h1) * 8'h10;
    endproperty
    a_subp: assert property (p_subp) else $error("subperiod count wrong");
    property p_mul;
        multiplier_ratio_reg == $past(p[31:28]) + 5'h1;
    endproperty
    a_mul: assert property (p_mul) else $error("multiplier ratio wrong");
endmodule
bind lmcfg_top lmcfg_assertions chk (.*);

// ===== verif/lmcfg_host.sv
`timescale 1ns/1ps
module lmcfg_host
(
    input wire ref_clk,
    output logic cmd_valid,
    output logic [15:0] cmd_id,
    output logic [47:0] cmd_data
);
    // quiet command port until the first request
    initial
    begin
        cmd_valid = 1'h0;
        cmd_id = 16'h0;
        cmd_data = 48'h0;
    end
    // one whole command per edge, entered just after a rising edge
    task send(input logic [15:0] id, input logic [47:0] d);
    begin
        cmd_valid = 1'h1;
        cmd_id = id;
        cmd_data = d;
        @(posedge ref_clk);
        #1;
    end
    endtask
    // released lines toggle so stale data never looks fresh
    task idle(input int n);
    begin
        cmd_valid = 1'h0;
        repeat (n)
        begin
            cmd_id = ~cmd_id;
            cmd_data = ~cmd_data;
            @(posedge ref_clk);
            #1;
        end
    end
    endtask
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
    localparam logic [47:0] PR = 48'h1000_700f_0107, PM = 48'hcff8_f8ff_f11f;
    localparam logic [47:0] TR = 48'h00e0_0094_a400, TM = 48'h7fff_ffff_ffff;
    logic ref_clk = 1'h0;
    logic nrst = 1'h0;
    logic [47:0] mp, mt, d, t;
    int error_cnt = 0, samples_checked = 0, cyc = 0, i;
    int seed = 32'he7210231;
    wire cmd_valid, rd_valid_reg;
    wire [15:0] cmd_id;
    wire [47:0] cmd_data, rd_data_reg, pr, tr;
    wire [71:0] dec;
    lmcfg_host host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_id(cmd_id),
        .cmd_data(cmd_data));
    lmcfg_top dut (.ref_clk(ref_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_id(cmd_id),
        .cmd_data(cmd_data), .rd_valid_reg(rd_valid_reg), .rd_data_reg(rd_data_reg),
        .common_config_primary_reg(pr), .common_config_timing_reg(tr),
        .device_count_reg(dec[71:66]), .predischarge_enable_reg(dec[65]),
        .power_saving_enable_reg(dec[64]), .power_saving_plus_level_reg(dec[63:62]),
        .power_saving_plus_sel_reg(dec[61:59]), .open_load_removal_enable_reg(dec[58]),
        .scan_line_count_reg(dec[57:52]), .subperiod_count_reg(dec[51:44]),
        .multiplier_range_select_reg(dec[43]), .multiplier_ratio_reg(dec[42:38]),
        .group_delay_reg(dec[37:29]), .module_stack_size_reg(dec[28:27]),
        .stack_config_error_reg(dec[26]), .segment_clock_count_reg(dec[25:15]),
        .line_switch_interval_reg(dec[14:6]), .black_field_adjust_reg(dec[5:0]));
    // decoded meaning of both registers, in output port order
    function automatic logic [71:0] exp_dec(input logic [47:0] p, q);
        int sg, sw;
        logic [2:0] sel;
        logic [1:0] stk;
        begin
            sel = p[14:13] == 2'h0 ? 3'h0 : 3'h4 >> (p[14:13] - 2'h1);
            stk = p[47:46] == 2'h1 ? 2'h1 : (p[47:46] == 2'h3 ? 2'h3 : 2'h2);
            sg = q[9:0] >= 127 ? q[9:0] + 1 : 128;
            sw = q[40:37] == 0 ? 45 : (q[40:37] + 1) * 30;
            exp_dec = {6'(p[4:0] + 1), p[8], p[12], p[14:13], sel, p[15], 6'(p[20:16] + 1),
                8'((p[23:21] + 1) * 16), p[27], 5'(p[31:28] + 1), p[43:35], stk,
                p[47:46] == 2'h1 && p[20:16] > 5'hf, 11'(sg), 9'(sw), q[46:41]};
        end
    endfunction
    task chk(input logic [127:0] got, exp);
    begin
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    end
    endtask
    // reset held four edges, everything back to reset meaning
    task rst_chk;
    begin
        nrst = 1'h0;
        @(posedge ref_clk);
        #1;
        chk({rd_valid_reg, rd_data_reg, pr}, {49'h0, PR});
        chk(tr, TR);
        chk(dec, exp_dec(PR, TR));
        repeat (3) @(posedge ref_clk);
        #1;
        nrst = 1'h1;
        mp = PR;
        mt = TR;
        $display("reset test done");
    end
    endtask
    task end_sim;
    begin
        $display("checked %0d, wrong %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    // free-running clock and hang guard
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc > 2000)
        begin
            error_cnt++;
            end_sim();
        end
    end
    // random writes, back-to-back reads, a stray id, a mid-run reset
    initial
    begin
        rst_chk();
        for (i = 0; i < 32; i++)
        begin
            if (i == 16)
                rst_chk();
            d = 48'({$random(seed), $random(seed)});
            d[47:46] = i[1:0];
            d[14:13] = i[3:2];
            t = 48'({$random(seed), $random(seed)});
            t[9:0] = i[4] ? 10'(1023 - i[3:0]) : 10'(126 + i[3:0]);
            t[40:37] = i[3:0];
            host.send(16'haa00, d);
            mp = (d & PM) | (PR & ~PM);
            host.send(16'haa01, t);
            mt = (t & TM) | (TR & ~TM);
            host.send(16'haa60, ~d);
            chk({rd_valid_reg, rd_data_reg}, {1'h1, mp});
            host.send(16'haa61, d);
            chk({rd_valid_reg, rd_data_reg}, {1'h1, mt});
            host.send(16'haa02, ~d);
            host.idle(1 + ($random(seed) & 3));
            chk({rd_valid_reg, pr, tr}, {1'h0, mp, mt});
            chk(dec, exp_dec(mp, mt));
            $display("test %0d done", i);
        end
        end_sim();
    end
endmodule
